// ==== rtl/meter_cmd.sv ====
// remote command interpreter: parser, settings, panels, responses, error status
// Operation
// - drop responses over 300 bytes, flag query error
// - frequency accepts 120 or 1000 only
// - header switch prefixes command header to responses
// - header prefix is on after reset
// - bad argument gives execution error, setting kept
// - level accepts 1, 0.5 or 0.05
// - extra numeric digits rounded before validation
// - recall panel 1..99, empty panel is error
// - comparator measurement starts with combined decision
// - each comparator value followed by -1/0/1
// - compensation busy rejects measure and setting changes other than parameter and header
// - parameter pair is 1..5
// - range 1..10, also turns auto range off
// - automatic circuit mode picks series or parallel
// - auto range takes ON/OFF, query returns word
// - save panel 1..99, bad argument is command error
// - panel query returns 1 or 0, headerless
// - speed takes FAST/NORMAL/SLOW, query returns word
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module meter_cmd (
  input wire logic clk, // 100 MHz clock
  input wire logic resetn, // synchronous reset
  input wire logic rx_valid, // command byte present
  input wire logic [7:0] rx_data, // command byte
  output logic rx_ready, // command byte taken
  output logic tx_valid, // response byte present
  output logic [7:0] tx_data, // response byte
  input wire logic tx_ready, // response byte taken
  input wire logic [95:0] meas1_text, // first value text, right aligned
  input wire logic [3:0] meas1_len, // first value length in bytes
  input wire logic [95:0] meas2_text, // second value text, right aligned
  input wire logic [3:0] meas2_len, // second value length in bytes
  input wire logic [1:0] cmp1_dec, // first decision
  input wire logic [1:0] cmp2_dec, // second decision
  input wire logic cmp_active, // comparator mode on
  input wire logic comp_busy, // compensation in progress
  input wire logic eqc_auto, // circuit mode automatic
  output logic freq_1k, // tone rate 1000 when high
  output logic [1:0] level_sel, // signal level code
  output logic [2:0] par_sel, // parameter pair
  output logic [3:0] range_sel, // range number
  output logic range_auto, // automatic range
  output logic [1:0] speed_sel, // speed code
  output logic eqc_parallel, // parallel circuit chosen
  input wire logic [3:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [7:0] reg_rdata, // register read data
  output logic irq // unmasked error pending
);
  function automatic logic [389:0] app(input logic [389:0] a, input logic [95:0] p,
                                       input logic [3:0] n);
    logic [95:0] m;
    m = ~({96{1'b1}} << (8 * n));
    app = {a[389:384] + {2'h0, n}, (a[383:0] << (8 * n)) | {288'h0, p & m}};
  endfunction

  function automatic logic [23:0] dec_txt(input logic [1:0] d);
    dec_txt = (d == meter_pkg::DEC_LO) ? ",-1" : (d == meter_pkg::DEC_HI) ? ",1" : ",0";
  endfunction

  function automatic logic [3:0] dec_len(input logic [1:0] d);
    dec_len = (d == meter_pkg::DEC_LO) ? 4'h3 : 4'h2;
  endfunction

  function automatic logic [47:0] onoff(input logic b);
    onoff = b ? "ON" : "OFF";
  endfunction

  meter_pkg::state_e st_ff;
  meter_pkg::panel_s cond_ff;
  meter_pkg::panel_s panel_mem [1:meter_pkg::PANEL_COUNT];
  logic [meter_pkg::PANEL_COUNT:0] pvalid_ff;
  logic [71:0] seg_ff;
  logic [47:0] word_ff;
  logic prev_rng_ff, hbad_ff, query_ff, star_ff, abad_ff, has_num_ff, dot_ff;
  logic [10:0] int_ff;
  logic [3:0] f1_ff, f2_ff, f3_ff;
  logic [1:0] fc_ff;
  logic head_ff, eqc_par_ff;
  logic [8:0] msg_cnt_ff;
  logic [383:0] tx_buf_ff;
  logic [5:0] tx_cnt_ff;
  logic [7:0] tx_data_ff;
  logic [2:0] status_ff, mask_ff;
  logic [7:0] rdata_ff;
  logic [7:0] uc;
  logic is_alpha, is_digit, take, term, is_lf, exec;
  logic [14:0] int_next;
  logic [11:0] ival;
  logic [17:0] centi;
  logic num_ok, word_ok, arg_ok, blocks, busy_rej, cerr, eerr, apply, respond;
  logic too_long, qerr;
  meter_pkg::cmd_e cmd;
  logic [389:0] acc;
  logic [5:0] body_len;

  assign uc = (rx_data >= "a" && rx_data <= "z") ? (rx_data & ~meter_pkg::CASE_BIT) : rx_data;
  assign is_alpha = uc >= "A" && uc <= "Z";
  assign is_digit = uc >= "0" && uc <= "9";
  assign rx_ready = st_ff != meter_pkg::S_EMIT;
  assign take = rx_valid && rx_ready;
  assign is_lf = uc == meter_pkg::CH_LF;
  assign term = is_lf || uc == meter_pkg::CH_SEMI;
  assign exec = take && term;
  assign int_next = 15'(int_ff) * 15'h000a + {11'h0, uc[3:0]};

  // byte parser
  always_ff @(posedge clk) begin
    if (!resetn || exec) begin
      seg_ff <= '0;
      word_ff <= '0;
      {prev_rng_ff, hbad_ff, query_ff, star_ff, abad_ff, has_num_ff, dot_ff} <= '0;
      int_ff <= '0;
      {f1_ff, f2_ff, f3_ff} <= '0;
      fc_ff <= '0;
    end else if (take && st_ff == meter_pkg::S_HDR) begin
      if (is_alpha) begin
        seg_ff <= {seg_ff[63:0], uc};
        if (seg_ff[71:64] != 8'h00) hbad_ff <= 1'b1;
      end else if (uc == meter_pkg::CH_COLON) begin
        if (seg_ff == "RANG" || seg_ff == "RANGE") prev_rng_ff <= 1'b1;
        else if (seg_ff != '0) hbad_ff <= 1'b1;
        seg_ff <= '0;
      end else if (uc == meter_pkg::CH_QUERY) begin
        query_ff <= 1'b1;
      end else if (uc == meter_pkg::CH_STAR) begin
        star_ff <= 1'b1;
      end else if (uc != meter_pkg::CH_SPACE || star_ff) begin
        if (!star_ff) hbad_ff <= 1'b1;
      end
    end else if (take && st_ff == meter_pkg::S_ARG) begin
      if (is_alpha) begin
        word_ff <= {word_ff[39:0], uc};
        if (word_ff[47:40] != 8'h00 || has_num_ff) abad_ff <= 1'b1;
      end else if (is_digit) begin
        has_num_ff <= 1'b1;
        if (word_ff != '0) abad_ff <= 1'b1;
        if (!dot_ff) begin
          int_ff <= (int_next > 15'(meter_pkg::INT_SAT)) ? meter_pkg::INT_SAT : int_next[10:0];
        end else begin
          // digits past the third decimal are dropped
          unique case (fc_ff)
            2'h0: f1_ff <= uc[3:0];
            2'h1: f2_ff <= uc[3:0];
            2'h2: f3_ff <= uc[3:0];
            2'h3: ;
          endcase
          if (fc_ff != 2'h3) fc_ff <= fc_ff + 2'h1;
        end
      end else if (uc == meter_pkg::CH_DOT) begin
        if (dot_ff) abad_ff <= 1'b1;
        dot_ff <= 1'b1;
      end else if (uc != meter_pkg::CH_SPACE) begin
        abad_ff <= 1'b1;
      end
    end
  end

  // parser state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_ff <= meter_pkg::S_HDR;
    end else if (exec) begin
      st_ff <= (acc[389:384] != 6'h00) ? meter_pkg::S_EMIT : meter_pkg::S_HDR;
    end else if (take && st_ff == meter_pkg::S_HDR && uc == meter_pkg::CH_SPACE) begin
      st_ff <= meter_pkg::S_ARG;
    end else if (st_ff == meter_pkg::S_EMIT && tx_ready && tx_cnt_ff == 6'h01) begin
      st_ff <= meter_pkg::S_HDR;
    end
  end

  // round at the first dropped decimal place
  assign ival = {1'b0, int_ff} + {11'h0, f1_ff >= meter_pkg::ROUND_DIGIT};
  assign centi = 18'(int_ff) * 18'h00064 + 18'(f1_ff) * 18'h0000a + 18'(f2_ff)
               + {17'h0, f3_ff >= meter_pkg::ROUND_DIGIT};
  assign num_ok = has_num_ff && !abad_ff && word_ff == '0;
  assign word_ok = !abad_ff && !has_num_ff;

  // command decode
  always_comb begin
    cmd = meter_pkg::C_BAD;
    if (star_ff) cmd = meter_pkg::C_NONE;
    else if (hbad_ff) cmd = meter_pkg::C_BAD;
    else if (prev_rng_ff) cmd = (seg_ff == "AUTO") ? meter_pkg::C_AUTO : meter_pkg::C_BAD;
    else if (seg_ff == '0) cmd = query_ff ? meter_pkg::C_BAD : meter_pkg::C_NONE;
    else if (seg_ff == "FREQ" || seg_ff == "FREQUENCY") cmd = meter_pkg::C_FREQ;
    else if (seg_ff == "HEAD" || seg_ff == "HEADER") cmd = meter_pkg::C_HEAD;
    else if (seg_ff == "LEV" || seg_ff == "LEVEL") cmd = meter_pkg::C_LEV;
    else if (seg_ff == "LOAD") cmd = meter_pkg::C_LOAD;
    else if (seg_ff == "MEAS" || seg_ff == "MEASURE") cmd = meter_pkg::C_MEAS;
    else if (seg_ff == "PAR" || seg_ff == "PARAMETER") cmd = meter_pkg::C_PAR;
    else if (seg_ff == "RANG" || seg_ff == "RANGE") cmd = meter_pkg::C_RANG;
    else if (seg_ff == "SAVE") cmd = meter_pkg::C_SAVE;
    else if (seg_ff == "SPEE" || seg_ff == "SPEED") cmd = meter_pkg::C_SPEE;
  end

  // argument check and error classes
  always_comb begin
    arg_ok = 1'b0;
    unique case (cmd)
      meter_pkg::C_FREQ: arg_ok = num_ok && (ival == meter_pkg::FREQ_LO_VAL
                                  || ival == meter_pkg::FREQ_HI_VAL);
      meter_pkg::C_LEV: arg_ok = num_ok && (centi == meter_pkg::LEV_1_CENTI
                                 || centi == meter_pkg::LEV_05_CENTI
                                 || centi == meter_pkg::LEV_005_CENTI);
      meter_pkg::C_LOAD, meter_pkg::C_SAVE: arg_ok = num_ok && ival >= meter_pkg::PANEL_MIN
                                                     && ival <= meter_pkg::PANEL_MAX;
      meter_pkg::C_PAR: arg_ok = num_ok && ival >= 12'h001 && ival <= meter_pkg::PAR_MAX;
      meter_pkg::C_RANG: arg_ok = num_ok && ival >= 12'h001 && ival <= meter_pkg::RANGE_MAX;
      meter_pkg::C_HEAD, meter_pkg::C_AUTO: arg_ok = word_ok
                                            && (word_ff == "ON" || word_ff == "OFF");
      meter_pkg::C_SPEE: arg_ok = word_ok && (word_ff == "FAST" || word_ff == "SLOW"
                                  || word_ff == "NORM" || word_ff == "NORMAL");
      default: arg_ok = 1'b0;
    endcase
    blocks = cmd inside {meter_pkg::C_FREQ, meter_pkg::C_LEV, meter_pkg::C_LOAD,
                         meter_pkg::C_RANG, meter_pkg::C_AUTO, meter_pkg::C_SPEE,
                         meter_pkg::C_SAVE};
    busy_rej = comp_busy && ((blocks && !query_ff) || (cmd == meter_pkg::C_MEAS && query_ff));
    cerr = cmd == meter_pkg::C_BAD || (query_ff && cmd == meter_pkg::C_LOAD)
         || (!query_ff && cmd == meter_pkg::C_MEAS)
         || (!query_ff && cmd == meter_pkg::C_SAVE && !busy_rej && !arg_ok);
    eerr = busy_rej
         || (!query_ff && !arg_ok && !(cmd inside {meter_pkg::C_NONE, meter_pkg::C_BAD,
             meter_pkg::C_MEAS, meter_pkg::C_SAVE}))
         || (query_ff && cmd == meter_pkg::C_SAVE && !(num_ok && ival <= meter_pkg::PANEL_MAX))
         || (!query_ff && cmd == meter_pkg::C_LOAD && arg_ok && !busy_rej
             && !pvalid_ff[ival[6:0]]);
    apply = exec && !query_ff && !cerr && !eerr;
    respond = query_ff && !cerr && !eerr && !(cmd inside {meter_pkg::C_NONE});
  end

  // response assembly
  always_comb begin
    acc = '0;
    if (msg_cnt_ff != 9'h000) acc = app(acc, ";", 4'h1);
    if (respond) begin
      unique case (cmd)
        meter_pkg::C_FREQ: begin
          if (head_ff) acc = app(acc, ":FREQUENCY ", 4'hb);
          acc = cond_ff.freq_1k ? app(acc, "1000", 4'h4) : app(acc, "120", 4'h3);
        end
        meter_pkg::C_HEAD: begin
          if (head_ff) acc = app(acc, ":HEADER ", 4'h8);
          acc = app(acc, onoff(head_ff), head_ff ? 4'h2 : 4'h3);
        end
        meter_pkg::C_LEV: begin
          if (head_ff) acc = app(acc, ":LEVEL ", 4'h7);
          unique case (cond_ff.lev)
            meter_pkg::LEV_V05: acc = app(acc, "0.5", 4'h3);
            meter_pkg::LEV_V005: acc = app(acc, "0.05", 4'h4);
            default: acc = app(acc, "1", 4'h1);
          endcase
        end
        meter_pkg::C_PAR: begin
          if (head_ff) acc = app(acc, ":PARAMETER ", 4'hb);
          acc = app(acc, {88'h0, meter_pkg::CH_ZERO | {5'h0, cond_ff.par}}, 4'h1);
        end
        meter_pkg::C_RANG: begin
          if (head_ff) acc = app(acc, ":RANGE ", 4'h7);
          acc = (cond_ff.rng == 4'ha) ? app(acc, "10", 4'h2)
              : app(acc, {88'h0, meter_pkg::CH_ZERO | {4'h0, cond_ff.rng}}, 4'h1);
        end
        meter_pkg::C_AUTO: begin
          if (head_ff) acc = app(acc, ":RANGE:AUTO ", 4'hc);
          acc = app(acc, onoff(cond_ff.autor), cond_ff.autor ? 4'h2 : 4'h3);
        end
        meter_pkg::C_SPEE: begin
          if (head_ff) acc = app(acc, ":SPEED ", 4'h7);
          unique case (cond_ff.spd)
            meter_pkg::SPD_FAST: acc = app(acc, "FAST", 4'h4);
            meter_pkg::SPD_SLOW: acc = app(acc, "SLOW", 4'h4);
            default: acc = app(acc, "NORMAL", 4'h6);
          endcase
        end
        meter_pkg::C_SAVE: acc = pvalid_ff[ival[6:0]] ? app(acc, "1", 4'h1)
                               : app(acc, "0", 4'h1);
        meter_pkg::C_MEAS: begin
          if (cmp_active) begin
            acc = (cmp1_dec != meter_pkg::DEC_IN || (cond_ff.par != 3'h5
                   && cmp2_dec != meter_pkg::DEC_IN)) ? app(acc, "1,", 4'h2)
                : app(acc, "0,", 4'h2);
          end
          if (head_ff) begin
            unique case (cond_ff.par)
              3'h2: acc = app(acc, "C ", 4'h2);
              3'h3, 3'h4: acc = app(acc, "L ", 4'h2);
              3'h5: acc = app(acc, "R ", 4'h2);
              default: acc = app(acc, "Z ", 4'h2);
            endcase
          end
          acc = app(acc, meas1_text, meas1_len);
          if (cmp_active) acc = app(acc, {72'h0, dec_txt(cmp1_dec)}, dec_len(cmp1_dec));
          if (cond_ff.par != 3'h5) begin
            acc = app(acc, ",", 4'h1);
            if (head_ff) begin
              unique case (cond_ff.par)
                3'h1: acc = app(acc, "PHASE ", 4'h6);
                3'h4: acc = app(acc, "Q ", 4'h2);
                default: acc = app(acc, "D ", 4'h2);
              endcase
            end
            acc = app(acc, meas2_text, meas2_len);
            if (cmp_active) acc = app(acc, {72'h0, dec_txt(cmp2_dec)}, dec_len(cmp2_dec));
          end
        end
        default: acc = acc;
      endcase
    end
    body_len = acc[389:384];
    too_long = ({1'b0, msg_cnt_ff} + {4'h0, body_len}) > 10'(meter_pkg::MAX_RESP);
    if (!respond || too_long) acc = '0;
    if (is_lf && (msg_cnt_ff != 9'h000 || acc[389:384] != 6'h00)) acc = app(acc, "\n", 4'h1);
    qerr = respond && too_long;
  end

  // settings and panels
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cond_ff <= meter_pkg::COND_RST;
      head_ff <= 1'b1;
      eqc_par_ff <= 1'b0;
      pvalid_ff <= '0;
    end else if (apply) begin
      unique case (cmd)
        meter_pkg::C_FREQ: cond_ff.freq_1k <= ival == meter_pkg::FREQ_HI_VAL;
        meter_pkg::C_HEAD: head_ff <= word_ff == "ON";
        meter_pkg::C_LEV: cond_ff.lev <= (centi == meter_pkg::LEV_1_CENTI) ? meter_pkg::LEV_V1
                             : (centi == meter_pkg::LEV_05_CENTI) ? meter_pkg::LEV_V05
                             : meter_pkg::LEV_V005;
        meter_pkg::C_LOAD: cond_ff <= panel_mem[ival[6:0]];
        meter_pkg::C_PAR: cond_ff.par <= ival[2:0];
        meter_pkg::C_RANG: begin
          cond_ff.rng <= ival[3:0];
          cond_ff.autor <= 1'b0;
          if (eqc_auto) eqc_par_ff <= ival[3:0] >= meter_pkg::EQC_PAR_FROM;
        end
        meter_pkg::C_AUTO: cond_ff.autor <= word_ff == "ON";
        meter_pkg::C_SAVE: pvalid_ff[ival[6:0]] <= 1'b1;
        meter_pkg::C_SPEE: cond_ff.spd <= (word_ff == "FAST") ? meter_pkg::SPD_FAST
                              : (word_ff == "SLOW") ? meter_pkg::SPD_SLOW
                              : meter_pkg::SPD_NORMAL;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (apply && cmd == meter_pkg::C_SAVE) panel_mem[ival[6:0]] <= cond_ff;
  end

  // response byte count per message, cleared at line feed
  always_ff @(posedge clk) begin
    if (!resetn || (exec && is_lf)) msg_cnt_ff <= '0;
    else if (exec) msg_cnt_ff <= msg_cnt_ff + {3'h0, acc[389:384]};
  end

  // response transmitter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_buf_ff <= '0;
      tx_cnt_ff <= '0;
      tx_data_ff <= '0;
    end else if (exec && acc[389:384] != 6'h00) begin
      tx_buf_ff <= acc[383:0];
      tx_cnt_ff <= acc[389:384];
      tx_data_ff <= acc[8 * (acc[389:384] - 6'h01) +: 8];
    end else if (tx_cnt_ff != 6'h00 && tx_ready) begin
      tx_cnt_ff <= tx_cnt_ff - 6'h01;
      if (tx_cnt_ff > 6'h01) tx_data_ff <= tx_buf_ff[8 * (tx_cnt_ff - 6'h02) +: 8];
    end
  end

  // error status, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_ff <= meter_pkg::STATUS_RST;
    end else begin
      status_ff <= (status_ff & ~((reg_wr && reg_addr == meter_pkg::A_STATUS) ? reg_wdata[2:0]
                   : 3'h0)) | ({eerr, cerr, qerr} & {3{exec}});
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) mask_ff <= meter_pkg::MASK_RST;
    else if (reg_wr && reg_addr == meter_pkg::A_MASK) mask_ff <= reg_wdata[2:0];
  end

  always_ff @(posedge clk) begin
    if (!resetn || !reg_rd) rdata_ff <= '0;
    else if (reg_addr == meter_pkg::A_STATUS) rdata_ff <= {5'h0, status_ff};
    else if (reg_addr == meter_pkg::A_MASK) rdata_ff <= {5'h0, mask_ff};
    else if (reg_addr == meter_pkg::A_SETTING)
      rdata_ff <= {head_ff, cond_ff.autor, cond_ff.freq_1k, eqc_par_ff, cond_ff.rng};
    else rdata_ff <= '0;
  end

  assign reg_rdata = rdata_ff;
  assign irq = |(status_ff & mask_ff);
  assign tx_valid = tx_cnt_ff != 6'h00;
  assign tx_data = tx_data_ff;
  assign freq_1k = cond_ff.freq_1k;
  assign level_sel = cond_ff.lev;
  assign par_sel = cond_ff.par;
  assign range_sel = cond_ff.rng;
  assign range_auto = cond_ff.autor;
  assign speed_sel = cond_ff.spd;
  assign eqc_parallel = eqc_par_ff;

  property p_qerr_long;
    @(posedge clk) disable iff (!resetn) exec && respond && too_long |=> status_ff[0];
  endproperty
  a_qerr_long: assert property (p_qerr_long) else $error("long response without query error");
  logic freq_hi;
  assign freq_hi = ival == meter_pkg::FREQ_HI_VAL;
  property p_freq_set;
    @(posedge clk) disable iff (!resetn)
      apply && cmd == meter_pkg::C_FREQ |=> freq_1k == $past(freq_hi);
  endproperty
  a_freq_set: assert property (p_freq_set) else $error("frequency not applied");
  property p_head_reset;
    @(posedge clk) $rose(resetn) |-> head_ff;
  endproperty
  a_head_reset: assert property (p_head_reset) else $error("header off after reset");
  property p_bad_keeps;
    @(posedge clk) disable iff (!resetn)
      exec && eerr |=> $stable(cond_ff) && status_ff[2];
  endproperty
  a_bad_keeps: assert property (p_bad_keeps) else $error("setting changed on error");
  property p_empty_panel;
    @(posedge clk) disable iff (!resetn)
      exec && !query_ff && cmd == meter_pkg::C_LOAD && num_ok && !comp_busy
      && ival == 12'h001 && !pvalid_ff[1] |=> status_ff[2];
  endproperty
  a_empty_panel: assert property (p_empty_panel) else $error("empty panel recalled");
  property p_busy_meas;
    @(posedge clk) disable iff (!resetn)
      exec && comp_busy && query_ff && cmd == meter_pkg::C_MEAS |=> status_ff[2];
  endproperty
  a_busy_meas: assert property (p_busy_meas) else $error("measure taken while busy");
  property p_range_auto_off;
    @(posedge clk) disable iff (!resetn)
      apply && cmd == meter_pkg::C_RANG |=> !range_auto ##1 range_auto == $past(range_auto);
  endproperty
  a_range_auto_off: assert property (p_range_auto_off) else $error("auto left on");
  property p_save_cerr;
    @(posedge clk) disable iff (!resetn)
      exec && !query_ff && cmd == meter_pkg::C_SAVE && !comp_busy && !arg_ok |=> status_ff[1];
  endproperty
  a_save_cerr: assert property (p_save_cerr) else $error("bad save without command error");
endmodule

// ==== rtl/meter_pkg.sv ====
// constants and types shared by the remote command interpreter
package meter_pkg;
  localparam int MAX_RESP = 300;
  localparam int PANEL_COUNT = 99;
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_MASK = 4'h4;
  localparam logic [3:0] A_SETTING = 4'h8;
  localparam int B_QERR = 0;
  localparam int B_CERR = 1;
  localparam int B_EERR = 2;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [11:0] PANEL_MIN = 12'h001;
  localparam logic [11:0] PANEL_MAX = 12'h063;
  localparam logic [11:0] PAR_MAX = 12'h005;
  localparam logic [11:0] RANGE_MAX = 12'h00a;
  localparam logic [11:0] FREQ_LO_VAL = 12'h078;
  localparam logic [11:0] FREQ_HI_VAL = 12'h3e8;
  localparam logic [17:0] LEV_1_CENTI = 18'h00064;
  localparam logic [17:0] LEV_05_CENTI = 18'h00032;
  localparam logic [17:0] LEV_005_CENTI = 18'h00005;
  localparam logic [10:0] INT_SAT = 11'h7ff;
  localparam logic [3:0] ROUND_DIGIT = 4'h5;
  localparam logic [3:0] EQC_PAR_FROM = 4'h6;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [1:0] DEC_IN = 2'h0;
  localparam logic [1:0] DEC_LO = 2'h1;
  localparam logic [1:0] DEC_HI = 2'h2;
  typedef enum logic [1:0] {LEV_V1, LEV_V05, LEV_V005} lev_e;
  typedef enum logic [1:0] {SPD_FAST, SPD_NORMAL, SPD_SLOW} spd_e;
  typedef enum logic [3:0] {C_NONE, C_BAD, C_FREQ, C_HEAD, C_LEV, C_LOAD, C_MEAS, C_PAR,
                            C_RANG, C_AUTO, C_SAVE, C_SPEE} cmd_e;
  typedef enum logic [1:0] {S_HDR, S_ARG, S_EMIT} state_e;
  typedef struct packed {
    logic freq_1k;
    lev_e lev;
    logic [2:0] par;
    logic [3:0] rng;
    logic autor;
    spd_e spd;
  } panel_s;
  localparam panel_s COND_RST = '{freq_1k: 1'b1, lev: LEV_V1, par: 3'h1, rng: 4'h1,
                                  autor: 1'b1, spd: SPD_NORMAL};
endpackage

// ==== verif/host_model.sv ====
// host side: sends command text, gathers response bytes
`timescale 1ns/1ns
module host_model (
  input wire logic clk, // clock
  output logic rx_valid, // byte offered
  output logic [7:0] rx_data, // command byte
  input wire logic rx_ready, // byte taken
  input wire logic tx_valid, // response byte present
  input wire logic [7:0] tx_data, // response byte
  output logic tx_ready // response byte accepted
);
  string resp = "";
  logic slow = 1'b0;
  initial rx_valid = 1'b0;
  initial rx_data = 8'h00;
  initial tx_ready = 1'b1;
  always @(posedge clk) begin
    if (tx_valid && tx_ready) resp = {resp, string'(tx_data)};
    tx_ready <= !slow || !tx_ready;
  end
  task automatic send(input string s);
    resp = "";
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= s[i];
      do @(negedge clk); while (!rx_ready);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    repeat (2) @(negedge clk);
    while (tx_valid) @(negedge clk);
  endtask
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the command interpreter
`timescale 1ns/1ns
module tb;
  typedef logic [255:0] txt_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic comp_busy = 1'b0;
  logic cmp_active = 1'b0;
  logic eqc_auto = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [95:0] meas1_text = "1.0";
  logic [95:0] meas2_text = "0.28";
  logic [3:0] meas1_len = 4'h3;
  logic [3:0] meas2_len = 4'h4;
  logic [1:0] cmp1_dec = meter_pkg::DEC_LO;
  logic [1:0] cmp2_dec = meter_pkg::DEC_IN;
  logic rx_valid, rx_ready, tx_valid, tx_ready, freq_1k, range_auto, eqc_parallel, irq;
  logic [7:0] rx_data, tx_data, reg_rdata;
  logic [1:0] level_sel, speed_sel;
  logic [2:0] par_sel;
  logic [3:0] range_sel;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  meter_cmd meter_cmd_inst (.clk, .resetn, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
    .tx_ready, .meas1_text, .meas1_len, .meas2_text, .meas2_len, .cmp1_dec, .cmp2_dec,
    .cmp_active, .comp_busy, .eqc_auto, .freq_1k, .level_sel, .par_sel, .range_sel, .range_auto,
    .speed_sel, .eqc_parallel, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  host_model host_model_inst (.clk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
    .tx_ready);
  task automatic chk(input txt_t g, input txt_t e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmd(input string s, input string e);
    host_model_inst.send(s);
    chk(txt_t'(host_model_inst.resp), txt_t'(e));
  endtask
  task automatic reg_op(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clk);
    if (!w) chk(txt_t'(reg_rdata), txt_t'(d));
  endtask
  task automatic err_seen(input logic [7:0] st);
    reg_op(1'b0, meter_pkg::A_STATUS, st);
    chk(txt_t'(irq), txt_t'(st[2]));
    reg_op(1'b1, meter_pkg::A_STATUS, st);
  endtask
  task automatic t_settings;
    reg_op(1'b1, meter_pkg::A_MASK, 8'h04);
    cmd(":FREQ?\n", ":FREQUENCY 1000\n");
    cmd(":head off;:Freq 120;:LEV 0.499;:FREQ?;:LEV?\n", "120;0.5\n");
    chk(txt_t'(level_sel), txt_t'(2'h1));
    cmd(":PAR 5;:PAR?;:PAR 6;:PAR 1.5;:PAR?\n", "5;2\n");
    chk(txt_t'(par_sel), txt_t'(3'h2));
    cmd(":FREQ 500\n", "");
    chk(txt_t'(freq_1k), txt_t'(1'b0));
    err_seen(8'h04);
    reg_op(1'b0, 4'h2, 8'h00);
    chk(txt_t'(irq), txt_t'(1'b0));
  endtask
  task automatic t_range_panels;
    cmd(":RANG 7;:RANG?;:RANG:AUTO?\n", "7;OFF\n");
    chk(txt_t'(eqc_parallel), txt_t'(1'b1));
    @(posedge clk);
    eqc_auto <= 1'b0;
    cmd(":RANG 2\n", "");
    chk(txt_t'(eqc_parallel), txt_t'(1'b1));
    chk(txt_t'(range_sel), txt_t'(4'h2));
    chk(txt_t'(range_auto), txt_t'(1'b0));
    cmd(":RANG:AUTO ON;:RANG:AUTO?\n", "ON\n");
    cmd(":SAVE 3;:SAVE? 3;:SAVE? 4\n", "1;0\n");
    cmd(":FREQ 1000;:LOAD 3;:FREQ?\n", "120\n");
    cmd(":LOAD 1\n", "");
    err_seen(8'h04);
    cmd(":SAVE 100\n", "");
    err_seen(8'h02);
  endtask
  task automatic t_busy_meas;
    @(posedge clk);
    comp_busy <= 1'b1;
    cmd(":SPEE SLOW;:MEAS?\n", "");
    err_seen(8'h04);
    @(posedge clk);
    comp_busy <= 1'b0;
    host_model_inst.slow = 1'b1;
    cmd(":SPEE?;:SPEE FAST;:SPEE?\n", "NORMAL;FAST\n");
    chk(txt_t'(speed_sel), txt_t'(2'h0));
    @(posedge clk);
    cmp_active <= 1'b1;
    cmd(":MEAS?\n", "1,1.0,-1,0.28,0\n");
  endtask
  task automatic t_long;
    string s;
    s = "";
    for (int i = 0; i < 60; i++) s = {s, ":SPEE?;"};
    host_model_inst.send({s, ":SPEE?\n"});
    chk(txt_t'(host_model_inst.resp.len()), txt_t'(300));
    err_seen(8'h01);
  endtask
  task automatic finish_test;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      finish_test;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_settings;
    t_range_panels;
    t_busy_meas;
    t_long;
    finish_test;
  end
endmodule
